// >>> ufb_pkg.sv
// Constants, types and summary for the serial port support block
// Summary of operation
// - Auto flow control only when modem control bits 5 and 1 both set.
// - On CTS rising, finish current stop bit, then halt transmit.
// - Resume transmit once CTS goes low again.
// - Receive interrupt when receive FIFO level reaches trigger level.
// - Auto RTS goes high only at the next trigger level above programmed, or at FIFO full for the top level.
// - Auto RTS returns low once the receive FIFO is empty.
// - Receiver keeps accepting characters while RTS is off, until full.
// - Data ready and time-out share one level, enabled by mask bit 0.
// - No receive time-out while the receive FIFO is empty.
// - Time-out counter restarts at stop bit centre and at holding reads.
// - Time-out fires after four character times.
// - One 16-bit divisor, 1 to 65535, makes the shared 16x tick.
// - Receiver clock stays off after reset until unlock sequence.
// - Mask bit 4 enters sleep with oscillator off; clearing it leaves.
// - Sleep ends with start bit, RX or CTS change, or transmit write.
// - Woken with sleep still set, sleep again once idle.
// - Never enter sleep while an interrupt is pending.
// - Low power gates only the core clock; same wake conditions.
// - Loopback ties transmit to receive and RTS to CTS internally.
// - Divisor bytes reachable only while format bit 7 is one.
package ufb_pkg;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_FMT = 3'h3;
  localparam logic [2:0] ADDR_MODEM = 3'h4;
  localparam logic [2:0] ADDR_LSTATE = 3'h5;
  localparam logic [2:0] ADDR_MSTATE = 3'h6;
  localparam int MODEM_AUTO = 5;
  localparam int MODEM_LOOP = 4;
  localparam int MODEM_RTS = 1;
  localparam logic [7:0] MODEM_KEEP = 8'h32;
  localparam int MASK_RX = 0;
  localparam int MASK_SLEEP = 4;
  localparam int MASK_LP = 5;
  localparam int FMT_DLAB = 7;
  localparam int FMT_STOP = 2;
  localparam int FMT_PAR = 3;
  localparam logic [7:0] UNLOCK_FMT = 8'h00;
  localparam logic [7:0] UNLOCK_END = 8'h20;
  localparam int KEY_COUNT = 5;
  localparam logic [7:0] UNLOCK_KEY [KEY_COUNT] =
    '{8'haa, 8'hcc, 8'h33, 8'ha5, 8'hc3};
  localparam int OVERSAMPLE = 16;
  localparam int TIMEOUT_CHARS = 4;
  localparam int MIN_WORD_BITS = 5;
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] TRIG_LEVEL [4] =
    '{7'h01, 7'h10, 7'h20, 7'h38};
  localparam logic [LEVEL_W-1:0] FIFO_FULL = 7'h40;
  localparam int TO_W = 10;
  typedef enum logic [1:0] {
    UNL_LOCKED = 2'b01,
    UNL_OPEN = 2'b10
  } ufb_unl_type;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b01,
    PWR_DOZE = 2'b10
  } ufb_pwr_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } ufb_host_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufb_char_type;
endpackage

// >>> ufb_support.sv
// Flow control, time-out, baud, unlock, power and loopback logic
`timescale 1ns/1ps
module ufb_support (
  input wire logic clock,
  input wire logic resetn,
  input wire ufb_pkg::ufb_host_type host,
  input wire logic [1:0] fifo_trigger,
  input wire logic [ufb_pkg::LEVEL_W-1:0] rx_level,
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  input wire logic core_tx,
  input wire logic tx_busy,
  input wire logic tx_stop_done,
  input wire logic tx_fifo_empty,
  input wire logic rx_stop_center,
  input wire logic other_irq,
  input wire ufb_pkg::ufb_char_type rx_in,
  input wire logic rx_out_ready,
  output logic rx_in_ready,
  output ufb_pkg::ufb_char_type rx_out,
  output logic tx_pin,
  output logic rts_n_pin,
  output logic core_rx,
  output logic core_cts_n,
  output logic tx_go,
  output logic baud_tick,
  output logic rx_clk_en,
  output logic rx_irq,
  output logic timeout_irq,
  output logic osc_en,
  output logic core_clk_en,
  output logic [7:0] line_format_reg
);
  import ufb_pkg::*;

  typedef struct packed {
    logic rx_m, rx_q, rx_d;
    logic cts_m, cts_q, cts_d;
    logic [7:0] fmt, modem_ctl, irq_mask, div_lo, div_hi;
    logic [15:0] baud_cnt;
    logic baud_tick;
    logic [TO_W-1:0] to_cnt;
    logic timeout_irq, rx_irq;
    logic rts_n, tx_go, tx_pin, core_rx, core_cts_n;
    logic osc_en, core_clk_en, rx_clk_en;
    ufb_unl_type unl;
    logic [2:0] key_idx;
    ufb_pwr_type pwr;
    logic [7:0] buf0, buf1;
    logic [1:0] buf_n;
    logic in_ready, out_valid;
  } ufb_state_type;

  ufb_state_type s, next_s;

  // Span of four characters in 16x ticks, framing bits included
  function automatic logic [TO_W-1:0] char_span(input logic [7:0] f);
    logic [3:0] bits;
    bits = 4'(1 + MIN_WORD_BITS) + {2'h0, f[1:0]} + {3'h0, f[FMT_PAR]}
      + (f[FMT_STOP] ? 4'h2 : 4'h1);
    return TO_W'(TIMEOUT_CHARS * OVERSAMPLE) * TO_W'(bits);
  endfunction

  logic dlab, thr_wr, hold_rd, auto_fc, loop, run, idle, pend, wake;
  logic push, pop;
  logic [15:0] divisor;
  logic [LEVEL_W-1:0] trig, trig_next;

  always_comb begin
    next_s = s;
    dlab = s.fmt[FMT_DLAB];
    divisor = {s.div_hi, s.div_lo};
    thr_wr = host.wr && host.addr == ADDR_HOLD && !dlab;
    hold_rd = host.rd && host.addr == ADDR_HOLD && !dlab;
    auto_fc = s.modem_ctl[MODEM_AUTO] && s.modem_ctl[MODEM_RTS];
    loop = s.modem_ctl[MODEM_LOOP];
    run = s.core_clk_en;
    trig = TRIG_LEVEL[fifo_trigger];
    trig_next = fifo_trigger == 2'h3 ? FIFO_FULL
      : TRIG_LEVEL[2'(fifo_trigger + 2'h1)];
    next_s.rx_m = rx_pin;
    next_s.rx_q = s.rx_m;
    next_s.rx_d = s.rx_q;
    next_s.cts_m = cts_n_pin;
    next_s.cts_q = s.cts_m;
    next_s.cts_d = s.cts_q;

    if (host.wr) begin
      unique case (host.addr)
        ADDR_HOLD: begin
          if (dlab) begin
            next_s.div_lo = host.data;
          end
        end
        ADDR_MASK: begin
          if (dlab) begin
            next_s.div_hi = host.data;
          end else begin
            next_s.irq_mask = host.data;
          end
        end
        ADDR_FMT: next_s.fmt = host.data;
        ADDR_MODEM: next_s.modem_ctl = host.data & MODEM_KEEP;
        default: ;
      endcase
    end

    // Unlock key walk; any wrong write starts the walk over
    unique case (s.unl)
      UNL_LOCKED: begin
        if (host.wr) begin
          next_s.key_idx = 3'h0;
          if (host.addr == ADDR_FMT && host.data == UNLOCK_FMT) begin
            next_s.key_idx = 3'h1;
          end else if (s.key_idx != 3'h0 && s.key_idx <= 3'(KEY_COUNT)
              && host.addr == ADDR_MSTATE
              && host.data == UNLOCK_KEY[s.key_idx - 3'h1]) begin
            next_s.key_idx = s.key_idx + 3'h1;
          end else if (s.key_idx == 3'(KEY_COUNT + 1)
              && host.addr == ADDR_LSTATE && host.data == UNLOCK_END) begin
            next_s.unl = UNL_OPEN;
          end
        end
      end
      UNL_OPEN: ;
    endcase
    next_s.rx_clk_en = next_s.unl == UNL_OPEN && next_s.core_clk_en;

    // Shared 16x tick; held frozen while the core clock is gated
    next_s.baud_tick = 1'b0;
    if (run && divisor != 16'h0000) begin
      if (s.baud_cnt >= divisor - 16'h0001) begin
        next_s.baud_cnt = 16'h0000;
        next_s.baud_tick = 1'b1;
      end else begin
        next_s.baud_cnt = s.baud_cnt + 16'h0001;
      end
    end

    // Loopback: pin TX parked at mark, RX and CTS fed internally
    next_s.tx_pin = loop ? 1'b1 : core_tx;
    next_s.core_rx = loop ? core_tx : s.rx_q;
    next_s.core_cts_n = loop ? s.rts_n : s.cts_q;

    // CTS halt waits for the stop bit of the character in flight
    if (!auto_fc || !s.core_cts_n) begin
      next_s.tx_go = 1'b1;
    end else if (!tx_busy || tx_stop_done) begin
      next_s.tx_go = 1'b0;
    end

    if (!auto_fc) begin
      next_s.rts_n = ~s.modem_ctl[MODEM_RTS];
    end else if (rx_level >= trig_next) begin
      next_s.rts_n = 1'b1;
    end else if (rx_level == '0) begin
      next_s.rts_n = 1'b0;
    end

    next_s.rx_irq = s.irq_mask[MASK_RX] && rx_level >= trig;

    if (rx_level == '0) begin
      next_s.to_cnt = '0;
      next_s.timeout_irq = 1'b0;
    end else if (rx_stop_center || hold_rd) begin
      next_s.to_cnt = '0;
      next_s.timeout_irq = 1'b0;
    end else if (s.baud_tick && s.to_cnt != char_span(s.fmt)) begin
      next_s.to_cnt = s.to_cnt + 1'b1;
    end
    if (s.irq_mask[MASK_RX] && rx_level != '0
        && s.to_cnt == char_span(s.fmt)) begin
      next_s.timeout_irq = 1'b1;
    end
    if (!s.irq_mask[MASK_RX]) begin
      next_s.timeout_irq = 1'b0;
    end

    // Two-entry buffer; ready drops only when both slots hold a word
    push = rx_in.valid && s.in_ready;
    pop = s.out_valid && rx_out_ready;
    unique case ({push, pop})
      2'b10: begin
        if (s.buf_n == 2'h0) begin
          next_s.buf0 = rx_in.data;
        end else begin
          next_s.buf1 = rx_in.data;
        end
        next_s.buf_n = s.buf_n + 2'h1;
      end
      2'b01: begin
        next_s.buf0 = s.buf1;
        next_s.buf_n = s.buf_n - 2'h1;
      end
      2'b11: begin
        if (s.buf_n == 2'h1) begin
          next_s.buf0 = rx_in.data;
        end else begin
          next_s.buf0 = s.buf1;
          next_s.buf1 = rx_in.data;
        end
      end
      default: ;
    endcase
    next_s.in_ready = next_s.buf_n != 2'h2;
    next_s.out_valid = next_s.buf_n != 2'h0;

    // Power: registers and FIFOs simply hold while clocks are gated
    pend = s.rx_irq || s.timeout_irq || other_irq;
    idle = tx_fifo_empty && !tx_busy && rx_level == '0 && s.buf_n == 2'h0;
    wake = !s.rx_q || s.rx_q != s.rx_d || s.cts_q != s.cts_d || thr_wr;
    unique case (s.pwr)
      PWR_RUN: begin
        if ((s.irq_mask[MASK_SLEEP] || s.irq_mask[MASK_LP]) && !pend && idle
            && !wake) begin
          next_s.pwr = PWR_DOZE;
        end
      end
      PWR_DOZE: begin
        if (wake || !(next_s.irq_mask[MASK_SLEEP]
            || next_s.irq_mask[MASK_LP])) begin
          next_s.pwr = PWR_RUN;
        end
      end
    endcase
    next_s.core_clk_en = next_s.pwr == PWR_RUN;
    next_s.osc_en = !(next_s.pwr == PWR_DOZE
      && next_s.irq_mask[MASK_SLEEP]);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.rx_m <= 1'b1;
      s.rx_q <= 1'b1;
      s.rx_d <= 1'b1;
      s.cts_m <= 1'b1;
      s.cts_q <= 1'b1;
      s.cts_d <= 1'b1;
      s.rts_n <= 1'b1;
      s.tx_go <= 1'b1;
      s.tx_pin <= 1'b1;
      s.core_rx <= 1'b1;
      s.core_cts_n <= 1'b1;
      s.osc_en <= 1'b1;
      s.core_clk_en <= 1'b1;
      s.unl <= UNL_LOCKED;
      s.pwr <= PWR_RUN;
      s.in_ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rx_in_ready = s.in_ready;
  assign rx_out = '{valid: s.out_valid, data: s.buf0};
  assign tx_pin = s.tx_pin;
  assign rts_n_pin = s.rts_n;
  assign core_rx = s.core_rx;
  assign core_cts_n = s.core_cts_n;
  assign tx_go = s.tx_go;
  assign baud_tick = s.baud_tick;
  assign rx_clk_en = s.rx_clk_en;
  assign rx_irq = s.rx_irq;
  assign timeout_irq = s.timeout_irq;
  assign osc_en = s.osc_en;
  assign core_clk_en = s.core_clk_en;
  assign line_format_reg = s.fmt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence cts_high_auto;
    auto_fc && s.core_cts_n && !tx_busy;
  endsequence
  sequence cts_low_auto;
    auto_fc && !s.core_cts_n;
  endsequence

  a_tx_halt_cts: assert property (
    cts_high_auto |=> !tx_go)
    else $error("transmit not halted by CTS");
  a_tx_resume_cts: assert property (
    cts_low_auto |=> tx_go)
    else $error("transmit not resumed after CTS low");
  a_rts_off_lvl: assert property (
    auto_fc && !rts_n_pin && rx_level < trig_next
      && $stable(rx_level) |=> !rts_n_pin)
    else $error("RTS raised below next trigger level");
  a_rts_on_empty: assert property (
    auto_fc && rx_level == '0 ##1 $stable(s.modem_ctl) |-> !rts_n_pin)
    else $error("RTS not lowered after FIFO emptied");
  a_no_timeout_empty: assert property (
    rx_level == '0 |=> !timeout_irq)
    else $error("time-out raised with empty FIFO");
  a_timeout_restart: assert property (
    rx_stop_center && rx_level != '0 |=> s.to_cnt == '0)
    else $error("time-out counter not restarted");
  a_rx_locked: assert property (
    s.unl == UNL_LOCKED |-> !rx_clk_en)
    else $error("receiver clock enabled before unlock");
  a_sleep_irq_block: assert property (
    s.pwr == PWR_RUN && (rx_irq || timeout_irq || other_irq)
      |=> s.pwr == PWR_RUN)
    else $error("entered sleep with interrupt pending");
  a_loop_cts_rts: assert property (
    loop && $stable(loop) |=> core_cts_n == $past(rts_n_pin))
    else $error("loopback CTS not fed from RTS");
  a_sleep_osc_off: assert property (
    s.pwr == PWR_DOZE && s.irq_mask[MASK_SLEEP] |-> !osc_en && !core_clk_en)
    else $error("oscillator running while asleep");
endmodule // ufb_support

// >>> ufb_remote.sv
// Remote serial device: drives the serial line and clear-to-send
`timescale 1ns/1ps
module ufb_remote (
  input wire logic clock,
  input wire logic hold_off,
  input wire logic send_start,
  output logic rx_pin,
  output logic cts_n_pin
);
  // Line rests high between characters, as a marking line does
  always_ff @(posedge clock) begin
    rx_pin <= ~send_start;
    cts_n_pin <= hold_off;
  end
endmodule // ufb_remote

// >>> ufb_support_test.sv
// Self-checking bench for the serial port support block
`timescale 1ns/1ps
module ufb_support_test;
  import ufb_pkg::*;
  logic clock = 0, resetn = 0, hold_off = 0, send_start = 0;
  ufb_host_type host = '0;
  ufb_char_type rx_in = '0, rx_out;
  logic [1:0] fifo_trigger = 0;
  logic [LEVEL_W-1:0] rx_level = 0;
  logic core_tx = 1, tx_busy = 0, tx_stop_done = 0, tx_fifo_empty = 1;
  logic rx_stop_center = 0, other_irq = 0, rx_out_ready = 0;
  logic rx_pin, cts_n_pin, rx_in_ready, tx_pin, rts_n_pin, core_rx;
  logic core_cts_n, tx_go, baud_tick, rx_clk_en, rx_irq, timeout_irq;
  logic osc_en, core_clk_en;
  logic [7:0] line_format_reg;
  int err_total = 0, comparisons = 0, k, n, sp;
  logic [7:0] q[$];
  always #50 clock = ~clock;
  ufb_remote far_u (.clock(clock), .hold_off(hold_off),
    .send_start(send_start), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin));
  ufb_support dut_u (.clock(clock), .resetn(resetn), .host(host),
    .fifo_trigger(fifo_trigger), .rx_level(rx_level), .rx_pin(rx_pin),
    .cts_n_pin(cts_n_pin), .core_tx(core_tx), .tx_busy(tx_busy),
    .tx_stop_done(tx_stop_done), .tx_fifo_empty(tx_fifo_empty),
    .rx_stop_center(rx_stop_center), .other_irq(other_irq),
    .rx_in(rx_in), .rx_out_ready(rx_out_ready), .rx_in_ready(rx_in_ready),
    .rx_out(rx_out), .tx_pin(tx_pin), .rts_n_pin(rts_n_pin),
    .core_rx(core_rx), .core_cts_n(core_cts_n), .tx_go(tx_go),
    .baud_tick(baud_tick), .rx_clk_en(rx_clk_en), .rx_irq(rx_irq),
    .timeout_irq(timeout_irq), .osc_en(osc_en),
    .core_clk_en(core_clk_en), .line_format_reg(line_format_reg));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Lands after the edge so registered outputs have settled
  task automatic step(int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic bus(logic w, logic [2:0] a, logic [7:0] d);
    @(posedge clock) host <= '{w, ~w, a, d};
    @(posedge clock) host <= '0;
  endtask
  task automatic unlock(logic [7:0] key2);
    bus(1, ADDR_FMT, UNLOCK_FMT);
    for (k = 0; k < KEY_COUNT; k++)
      bus(1, ADDR_MSTATE, (k == 2) ? key2 : UNLOCK_KEY[k]);
    bus(1, ADDR_LSTATE, UNLOCK_END);
    step(2);
  endtask
  task automatic lvl(logic [LEVEL_W-1:0] v, logic exp);
    @(posedge clock) rx_level <= v;
    step(3);
    check("rts_n_pin", rts_n_pin, exp);
  endtask
  task automatic close_out;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #3ms;
    err_total++;
    close_out();
  end
  initial begin
    void'($urandom(69089));
    repeat (5) @(posedge clock);
    resetn <= 1;
    step(1);
    check("reset", {rts_n_pin, tx_pin, core_rx, core_cts_n, tx_go, osc_en,
      core_clk_en, rx_in_ready, rx_clk_en, rx_irq, timeout_irq,
      baud_tick}, 12'hff0);
    unlock(8'h00);
    check("rx_clk_en bad key", rx_clk_en, 0);
    unlock(UNLOCK_KEY[2]);
    check("rx_clk_en", rx_clk_en, 1);
    // Divisor of 3 gives one tick every three cycles
    bus(1, ADDR_FMT, 8'h83);
    bus(1, ADDR_MASK, 8'h00);
    bus(1, ADDR_HOLD, 8'h03);
    bus(1, ADDR_FMT, 8'h03);
    step(2);
    n = 0;
    repeat (60) begin
      step(1);
      n += baud_tick;
    end
    check("ticks", n, 20);
    check("line_format_reg", line_format_reg, 8'h03);
    bus(1, ADDR_MODEM, 8'h20);
    @(posedge clock) hold_off <= 1;
    step(8);
    check("tx_go no auto", tx_go, 1);
    // Character already in flight when auto mode is enabled
    @(posedge clock) tx_busy <= 1;
    bus(1, ADDR_MODEM, 8'h22);
    step(8);
    check("tx_go in char", tx_go, 1);
    @(posedge clock) tx_stop_done <= 1;
    @(posedge clock) tx_stop_done <= 0;
    step(3);
    check("tx_go halted", tx_go, 0);
    @(posedge clock) hold_off <= 0;
    step(8);
    check("tx_go resumed", tx_go, 1);
    @(posedge clock) tx_busy <= 0;
    for (int t = 0; t < 4; t++) begin
      @(posedge clock) fifo_trigger <= 2'(t);
      n = (t < 3) ? TRIG_LEVEL[t + 1] : FIFO_FULL;
      lvl(0, 0);
      lvl(n - 1, 0);
      lvl(n, 1);
      check("rx_in_ready rts off", rx_in_ready, 1);
      lvl(1, 1);
      lvl(0, 0);
    end
    @(posedge clock) fifo_trigger <= 0;
    bus(1, ADDR_MASK, 8'h01);
    lvl(1, 0);
    check("rx_irq", rx_irq, 1);
    // Span: start, data, stop bits, four characters, 16 ticks each
    sp = TIMEOUT_CHARS * OVERSAMPLE * (1 + MIN_WORD_BITS + 3 + 1) * 3;
    @(posedge clock) rx_stop_center <= 1;
    @(posedge clock) rx_stop_center <= 0;
    step(sp - 12);
    check("timeout early", timeout_irq, 0);
    bus(0, ADDR_HOLD, 8'h00);
    step(sp - 12);
    check("timeout after read", timeout_irq, 0);
    step(24);
    check("timeout", timeout_irq, 1);
    lvl(0, 0);
    check("timeout empty", timeout_irq, 0);
    bus(1, ADDR_MASK, 8'h00);
    lvl(1, 0);
    check("rx_irq masked", rx_irq, 0);
    lvl(0, 0);
    // Fill the buffer with the reader stalled, then drain it
    @(posedge clock) rx_in <= '{1'b1, 8'($urandom)};
    repeat (6) begin
      @(posedge clock);
      if (rx_in_ready === 1'b1) begin
        q.push_back(rx_in.data);
        rx_in <= '{1'b1, 8'($urandom)};
      end
    end
    @(posedge clock) rx_in <= '0;
    check("buffer depth", q.size(), 2);
    check("buffer full", rx_in_ready, 0);
    @(posedge clock) rx_out_ready <= 1;
    repeat (6) begin
      @(posedge clock);
      if (rx_out.valid === 1'b1)
        check("rx_out", rx_out.data, q.pop_front());
    end
    check("buffer drained", q.size(), 0);
    rx_out_ready <= 0;
    bus(1, ADDR_MODEM, 8'h12);
    @(posedge clock) hold_off <= 1;
    repeat (4) begin
      @(posedge clock) core_tx <= 1'($urandom);
      step(3);
      check("core_rx loop", core_rx, core_tx);
      check("tx_pin loop", tx_pin, 1);
      check("core_cts_n loop", core_cts_n, 0);
      check("rts_n_pin loop", rts_n_pin, 0);
    end
    bus(1, ADDR_MODEM, 8'h00);
    @(posedge clock) other_irq <= 1;
    bus(1, ADDR_MASK, 8'h10);
    step(10);
    check("no doze pending", core_clk_en, 1);
    @(posedge clock) other_irq <= 0;
    step(10);
    check("sleep", {osc_en, core_clk_en}, 0);
    @(posedge clock) tx_fifo_empty <= 0;
    bus(1, ADDR_HOLD, 8'h55);
    step(3);
    check("wake tx write", core_clk_en, 1);
    @(posedge clock) tx_fifo_empty <= 1;
    step(10);
    check("sleep again", core_clk_en, 0);
    @(posedge clock) send_start <= 1;
    step(6);
    check("wake start", core_clk_en, 1);
    @(posedge clock) send_start <= 0;
    step(20);
    check("sleep after start", core_clk_en, 0);
    bus(1, ADDR_MASK, 8'h00);
    step(3);
    check("leave sleep", {osc_en, core_clk_en}, 3);
    bus(1, ADDR_MASK, 8'h20);
    step(10);
    check("low power", {osc_en, core_clk_en}, 2);
    check("format kept", line_format_reg, 8'h03);
    close_out();
  end
endmodule // ufb_support_test
